//--- design/meiu_pkg.sv
// Package: register map, field positions, reset values and timing for the event unit
//
// Notes on behaviour
// - Request output high while any flag bit and its mask bit are both set.
// - Supply-fail flag sets when the supply monitor reports supply below about 2.85V.
// - Checksum-change flag sets whenever the configuration checksum value changes.
// - Energy overflow flag sets when any per-phase energy accumulator overflows.
// - At cycle end, high-current flag sets if any phase RMS current exceeds threshold.
// - At cycle end, high-voltage flag sets if any phase RMS voltage exceeds threshold.
// - At cycle end, low-voltage flag sets if any phase RMS voltage fails to exceed threshold.
// - Missing-crossing flag sets when a phase has no crossing within timeout samples.
// - Real-flow-reversal flag sets when a phase's real energy sign differs from last cycle.
// - Reactive-flow-reversal flag sets when a phase's reactive sign differs from last cycle.
// - Cycle-done flag sets each time a processing cycle finishes.
// - Cycle-overrun flag sets when new cycle data arrives before processing finished.
// - While overrun flag is set, results are marked invalid.
// - Each phase keeps local flags mirroring its six condition bits.
// - Each phase keeps energy and fundamental overflow bits, one per accumulator.
// - Upper thresholds compare against bits 23 down to 8 of RMS values.
// - Flags are sticky; cleared only by reset or host write-one-to-clear.
// - Sample frame period equals (rate setting plus one) times 8 system clocks.
// - Current and voltage thresholds weigh full scale divided by 2 to the 16th.
// - Virtual reads return bits 47 down to 16 of raw value times the selected conversion coefficient.
package meiu_pkg;
    localparam int unsigned ADDR_W = 4;
    // Word indices on the Avalon bus
    localparam logic [ADDR_W-1:0] IDX_FLAG      = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_MASK      = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_THR_I     = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_THR_V     = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_TIMEOUT   = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_RATE      = 4'h5;
    localparam logic [ADDR_W-1:0] IDX_PH_FLAGS  = 4'h6;
    localparam logic [ADDR_W-1:0] IDX_PH_OVF    = 4'h7;
    localparam logic [ADDR_W-1:0] IDX_COEFF_SEL = 4'h8;
    localparam logic [ADDR_W-1:0] IDX_COEFF     = 4'h9;
    localparam logic [ADDR_W-1:0] IDX_VIRT_SEL  = 4'hA;
    localparam logic [ADDR_W-1:0] IDX_VIRT      = 4'hB;
    localparam logic [ADDR_W-1:0] IDX_STATUS    = 4'hC;
    // Global flag bit positions
    localparam int unsigned BIT_SUPPLY  = 0;
    localparam int unsigned BIT_CONFIG_CHECKSUM  = 1;
    localparam int unsigned BIT_ENERGY_OVERFLOW_FLAG    = 2;
    localparam int unsigned BIT_HI_I    = 3;
    localparam int unsigned BIT_HI_V    = 4;
    localparam int unsigned BIT_LO_V    = 5;
    localparam int unsigned BIT_MISSING_CROSSING_FLAG    = 6;
    localparam int unsigned BIT_REAL    = 7;
    localparam int unsigned BIT_REACT   = 8;
    localparam int unsigned BIT_DONE    = 9;
    localparam int unsigned BIT_OVERRUN = 10;
    localparam int unsigned FLAG_W      = 11;
    // Per-phase local flag positions
    localparam int unsigned PF_HI_I  = 0;
    localparam int unsigned PF_HI_V  = 1;
    localparam int unsigned PF_LO_V  = 2;
    localparam int unsigned PF_MISSING_CROSSING_FLAG  = 3;
    localparam int unsigned PF_REAL  = 4;
    localparam int unsigned PF_REACT = 5;
    localparam int unsigned PF_W     = 6;
    localparam int unsigned OVF_W    = 5;
    localparam int unsigned NPH      = 3;
    // Reset values
    localparam logic [FLAG_W-1:0] RST_MASK    = 11'h000;
    localparam logic [15:0]       RST_THR     = 16'hFFFF;
    localparam logic [15:0]       RST_THR_LO  = 16'h0000;
    localparam logic [15:0]       RST_TIMEOUT = 16'h0100;
    localparam logic [15:0]       RST_RATE    = 16'h013F;
    localparam logic [15:0]       RST_COEFF   = 16'h0001;
    // Frame timing
    localparam int unsigned FRAME_MUL = 8;
    localparam int unsigned CLK_HZ    = 40_000_000;
    localparam int unsigned SAMPLE_US = 40;
    localparam int unsigned SAMPLE_CYC_NOM = SAMPLE_US * (CLK_HZ / 1_000_000);
    // Read decode shared by bus logic
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a <= IDX_STATUS;
    endfunction
endpackage

//--- design/meiu_event_unit.sv
// Event flags, mask, per-phase status and bus slave of the metering event unit
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module meiu_event_unit
    import meiu_pkg::*;
#(
    parameter int unsigned RMS_W = 24,
    parameter int unsigned ACC_W = 32
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  sys_rst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // Supply monitor pin
    input  wire logic                  supply_low_i,
    // Zero-crossing pins, one per phase
    input  wire logic [NPH-1:0]        zero_cross_i,
    // Processing engine, same clock
    input  wire logic [15:0]           config_checksum_i,
    input  wire logic [NPH-1:0]        acc_overflow_i,
    input  wire logic [NPH*OVF_W-1:0]  phase_energy_overflow_i,
    input  wire logic [NPH*OVF_W-1:0]  phase_fundamental_overflow_i,
    input  wire logic                  cycle_done_i,
    input  wire logic                  cycle_start_i,
    input  wire logic [NPH*RMS_W-1:0]  rms_current_i,
    input  wire logic [NPH*RMS_W-1:0]  rms_voltage_i,
    input  wire logic [NPH-1:0]        real_sign_i,
    input  wire logic [NPH-1:0]        react_sign_i,
    input  wire logic [ACC_W-1:0]      virt_raw_i,
    // Outputs
    output logic                       irq_o,
    output logic                       results_valid_o,
    output logic                       frame_tick_o
);
    // Configuration registers
    logic [FLAG_W-1:0] flag_q;
    logic [FLAG_W-1:0] mask_q;
    logic [15:0]       thr_i_q;
    logic [15:0]       thr_v_hi_q;
    logic [15:0]       thr_v_lo_q;
    logic [15:0]       timeout_q;
    logic [15:0]       rate_q;
    logic [1:0]        coeff_sel_q;
    logic [15:0]       coeff_q [4];
    logic [PF_W-1:0]   ph_flag_q [NPH];
    logic [OVF_W-1:0]  ph_ovf_q [NPH];
    logic [OVF_W-1:0]  ph_fovf_q [NPH];
    logic [1:0]        virt_sel_q;
    logic [15:0]       chk_prev_q;
    logic [NPH-1:0]    rsign_q;
    logic [NPH-1:0]    qsign_q;
    logic              signs_valid_q;
    logic              busy_q;
    logic [NPH*PF_W-1:0] ph_event;
    logic [FLAG_W-1:0] set_d;

    // Bus handshake: one wait cycle then answer
    logic ack_q;
    logic req;
    logic wr_go;
    logic rd_go;
    assign req   = avs_read_i | avs_write_i;
    assign wr_go = avs_write_i & ack_q;
    assign rd_go = avs_read_i & ack_q;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(req & ~ack_q);
        end
    end

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    // Synchronisers for pin inputs
    logic          sup_m_q;
    logic          sup_s_q;
    logic [NPH-1:0] zx_m_q;
    logic [NPH-1:0] zx_s_q;
    logic [NPH-1:0] zx_p_q;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sup_m_q <= 1'b0;
            sup_s_q <= 1'b0;
            zx_m_q  <= '0;
            zx_s_q  <= '0;
            zx_p_q  <= '0;
        end else begin
            sup_m_q <= supply_low_i;
            sup_s_q <= sup_m_q;
            zx_m_q  <= zero_cross_i;
            zx_s_q  <= zx_m_q;
            zx_p_q  <= zx_s_q;
        end
    end

    // Frame timer: (rate+1)*8 clocks
    logic [18:0] frame_cnt_q;
    logic        frame_end;
    assign frame_end = frame_cnt_q >= ((19'(rate_q) + 19'd1) * 19'(FRAME_MUL) - 19'd1);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_cnt_q  <= '0;
            frame_tick_o <= 1'b0;
        end else begin
            frame_cnt_q  <= frame_end ? 19'd0 : frame_cnt_q + 19'd1;
            frame_tick_o <= frame_end;
        end
    end

    // Crossing timeout in sample periods
    logic [15:0]    zx_cnt_q [NPH];
    logic [NPH-1:0] zx_miss;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int p = 0; p < NPH; p++) begin
                zx_cnt_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPH; p++) begin
                if (zx_s_q[p] != zx_p_q[p]) begin
                    zx_cnt_q[p] <= '0;
                end else if (frame_end && !zx_miss[p]) begin
                    zx_cnt_q[p] <= zx_cnt_q[p] + 16'd1;
                end
            end
        end
    end
    always_comb begin
        for (int p = 0; p < NPH; p++) begin
            zx_miss[p] = (timeout_q != 16'd0) && (zx_cnt_q[p] >= timeout_q);
        end
    end

    // Per-phase condition events, thresholds on bits 23:8
    always_comb begin
        ph_event = '0;
        for (int p = 0; p < NPH; p++) begin
            if (cycle_done_i) begin
                ph_event[p*PF_W+PF_HI_I] = rms_current_i[p*RMS_W+8 +: 16] > thr_i_q;
                ph_event[p*PF_W+PF_HI_V] = rms_voltage_i[p*RMS_W+8 +: 16] > thr_v_hi_q;
                ph_event[p*PF_W+PF_LO_V] = !(rms_voltage_i[p*RMS_W+8 +: 16] > thr_v_lo_q);
                ph_event[p*PF_W+PF_REAL]  = signs_valid_q && (real_sign_i[p] != rsign_q[p]);
                ph_event[p*PF_W+PF_REACT] = signs_valid_q && (react_sign_i[p] != qsign_q[p]);
            end
            ph_event[p*PF_W+PF_MISSING_CROSSING_FLAG] = zx_miss[p];
        end
    end

    // Global set vector
    always_comb begin
        set_d = '0;
        set_d[BIT_SUPPLY] = sup_s_q;
        set_d[BIT_CONFIG_CHECKSUM] = config_checksum_i != chk_prev_q;
        set_d[BIT_ENERGY_OVERFLOW_FLAG]   = |acc_overflow_i;
        for (int p = 0; p < NPH; p++) begin
            set_d[BIT_HI_I]  = set_d[BIT_HI_I]  | ph_event[p*PF_W+PF_HI_I];
            set_d[BIT_HI_V]  = set_d[BIT_HI_V]  | ph_event[p*PF_W+PF_HI_V];
            set_d[BIT_LO_V]  = set_d[BIT_LO_V]  | ph_event[p*PF_W+PF_LO_V];
            set_d[BIT_MISSING_CROSSING_FLAG]  = set_d[BIT_MISSING_CROSSING_FLAG]  | ph_event[p*PF_W+PF_MISSING_CROSSING_FLAG];
            set_d[BIT_REAL]  = set_d[BIT_REAL]  | ph_event[p*PF_W+PF_REAL];
            set_d[BIT_REACT] = set_d[BIT_REACT] | ph_event[p*PF_W+PF_REACT];
        end
        set_d[BIT_DONE]    = cycle_done_i;
        set_d[BIT_OVERRUN] = cycle_start_i & busy_q & ~cycle_done_i;
    end

    // Engine tracking: checksum, signs, busy
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chk_prev_q    <= '0;
            rsign_q       <= '0;
            qsign_q       <= '0;
            signs_valid_q <= 1'b0;
            busy_q        <= 1'b0;
        end else begin
            chk_prev_q <= config_checksum_i;
            if (cycle_done_i) begin
                rsign_q       <= real_sign_i;
                qsign_q       <= react_sign_i;
                signs_valid_q <= 1'b1;
            end
            if (cycle_start_i) begin
                busy_q <= 1'b1;
            end else if (cycle_done_i) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Sticky global flags, set wins over clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_q <= '0;
        end else begin
            if (wr_go && avs_address_i == IDX_FLAG) begin
                flag_q <= (flag_q & ~avs_writedata_i[FLAG_W-1:0]) | set_d;
            end else begin
                flag_q <= flag_q | set_d;
            end
        end
    end

    // Per-phase local flags and overflow bits
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int p = 0; p < NPH; p++) begin
                ph_flag_q[p] <= '0;
                ph_ovf_q[p]  <= '0;
                ph_fovf_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPH; p++) begin
                if (wr_go && avs_address_i == IDX_PH_FLAGS) begin
                    ph_flag_q[p] <= (ph_flag_q[p] & ~avs_writedata_i[p*8 +: PF_W])
                                    | ph_event[p*PF_W +: PF_W];
                end else begin
                    ph_flag_q[p] <= ph_flag_q[p] | ph_event[p*PF_W +: PF_W];
                end
                if (wr_go && avs_address_i == IDX_PH_OVF) begin
                    ph_ovf_q[p]  <= (ph_ovf_q[p] & ~avs_writedata_i[p*5 +: OVF_W])
                                    | phase_energy_overflow_i[p*OVF_W +: OVF_W];
                    ph_fovf_q[p] <= (ph_fovf_q[p] & ~avs_writedata_i[16+p*5 +: OVF_W])
                                    | phase_fundamental_overflow_i[p*OVF_W +: OVF_W];
                end else begin
                    ph_ovf_q[p]  <= ph_ovf_q[p] | phase_energy_overflow_i[p*OVF_W +: OVF_W];
                    ph_fovf_q[p] <= ph_fovf_q[p] | phase_fundamental_overflow_i[p*OVF_W +: OVF_W];
                end
            end
        end
    end

    // Configuration writes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask_q      <= RST_MASK;
            thr_i_q     <= RST_THR;
            thr_v_hi_q  <= RST_THR;
            thr_v_lo_q  <= RST_THR_LO;
            timeout_q   <= RST_TIMEOUT;
            rate_q      <= RST_RATE;
            coeff_sel_q <= '0;
            virt_sel_q  <= '0;
            for (int k = 0; k < 4; k++) begin
                coeff_q[k] <= RST_COEFF;
            end
        end else if (wr_go) begin
            unique case (avs_address_i)
                IDX_MASK: begin
                    mask_q <= avs_writedata_i[FLAG_W-1:0];
                end
                IDX_THR_I: begin
                    thr_i_q <= wr16(thr_i_q, avs_writedata_i, avs_byteenable_i);
                end
                IDX_THR_V: begin
                    thr_v_hi_q <= wr16(thr_v_hi_q, avs_writedata_i, avs_byteenable_i);
                    if (avs_byteenable_i[3]) thr_v_lo_q[15:8] <= avs_writedata_i[31:24];
                    if (avs_byteenable_i[2]) thr_v_lo_q[7:0]  <= avs_writedata_i[23:16];
                end
                IDX_TIMEOUT: begin
                    timeout_q <= wr16(timeout_q, avs_writedata_i, avs_byteenable_i);
                end
                IDX_RATE: begin
                    rate_q <= wr16(rate_q, avs_writedata_i, avs_byteenable_i);
                end
                IDX_COEFF_SEL: begin
                    coeff_sel_q <= avs_writedata_i[1:0];
                end
                IDX_COEFF: begin
                    coeff_q[coeff_sel_q] <= wr16(coeff_q[coeff_sel_q], avs_writedata_i, avs_byteenable_i);
                end
                IDX_VIRT_SEL: begin
                    virt_sel_q <= avs_writedata_i[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Interrupt request, falls once nothing enabled remains
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flag_q & mask_q);
        end
    end

    // Results invalid while overrun flag stands
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            results_valid_o <= 1'b1;
        end else begin
            results_valid_o <= ~(flag_q[BIT_OVERRUN] | set_d[BIT_OVERRUN]);
        end
    end

    // Read data
    logic [47:0] virt_prod;
    assign virt_prod = virt_raw_i * coeff_q[virt_sel_q];
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_q) begin
            avs_readdata_o <= '0;
            if (is_mapped(avs_address_i)) begin
                unique case (avs_address_i)
                    IDX_FLAG:      avs_readdata_o <= 32'(flag_q);
                    IDX_MASK:      avs_readdata_o <= 32'(mask_q);
                    IDX_THR_I:     avs_readdata_o <= {16'h0000, thr_i_q};
                    IDX_THR_V:     avs_readdata_o <= {thr_v_lo_q, thr_v_hi_q};
                    IDX_TIMEOUT:   avs_readdata_o <= {16'h0000, timeout_q};
                    IDX_RATE:      avs_readdata_o <= {16'h0000, rate_q};
                    IDX_PH_FLAGS:  avs_readdata_o <= {8'h00, 2'b00, ph_flag_q[2], 2'b00, ph_flag_q[1],
                                                      2'b00, ph_flag_q[0]};
                    IDX_PH_OVF:    avs_readdata_o <= {1'b0, ph_fovf_q[2], ph_fovf_q[1], ph_fovf_q[0],
                                                      1'b0, ph_ovf_q[2], ph_ovf_q[1], ph_ovf_q[0]};
                    IDX_COEFF_SEL: avs_readdata_o <= {30'h0, coeff_sel_q};
                    IDX_COEFF:     avs_readdata_o <= {16'h0000, coeff_q[coeff_sel_q]};
                    IDX_VIRT_SEL:  avs_readdata_o <= {30'h0, virt_sel_q};
                    IDX_VIRT:      avs_readdata_o <= virt_prod[47:16];
                    IDX_STATUS:    avs_readdata_o <= {27'h0, busy_q, zx_miss, sup_s_q};
                    default:       avs_readdata_o <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- test/meiu_assertions.sv
// Port checker of the event unit
`timescale 1ns/1ps
`default_nettype none
module meiu_assertions
    import meiu_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              sys_rst_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              cycle_start_i,
    input wire logic              irq_o,
    input wire logic              results_valid_o,
    input wire logic              frame_tick_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o && $past(avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_ans: assert property (p_ans) else $error("request not answered");
    property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    property p_idle; !avs_read_i && !avs_write_i |=> avs_waitrequest_o; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $fell(sys_rst_i) |-> avs_waitrequest_o && !irq_o && results_valid_o && !frame_tick_o; endproperty
    a_rst: assert property (p_rst) else $error("bad reset levels");
    property p_irq_fall; $fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
    property p_rv_fall; $fell(results_valid_o) |-> $past(cycle_start_i) || $past(cycle_start_i, 2);
    endproperty
    a_rv_fall: assert property (p_rv_fall) else $error("results invalid without overrun");
    property p_rv_rise; $rose(results_valid_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
    endproperty
    a_rv_rise: assert property (p_rv_rise) else $error("overrun cleared by itself");
    property p_tick; frame_tick_o |=> !frame_tick_o [*7]; endproperty
    a_tick: assert property (p_tick) else $error("frame tick too close");
    c_irq: cover property ($rose(irq_o));
    c_rv: cover property ($fell(results_valid_o));
    c_tick: cover property (frame_tick_o);
endmodule
bind meiu_event_unit meiu_assertions i_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cycle_start_i(cycle_start_i), .irq_o(irq_o), .results_valid_o(results_valid_o), .frame_tick_o(frame_tick_o));
`default_nettype wire

//--- test/meiu_host_model.sv
// Host model: bus master reading and clearing flags
`timescale 1ns/1ps
`default_nettype none
module meiu_host_model
    import meiu_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              waitreq_i,
    input  wire logic [31:0]       rdata_i,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   rd_o,
    output logic                   wr_o,
    output logic [31:0]            wdata_o,
    output logic [3:0]             be_o
);
    initial begin
        addr_o = '0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = '0;
        be_o = 4'hF;
    end
    // One access; flags cleared by writing ones
    task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        rd_o <= ~w;
        wr_o <= w;
        do @(posedge clock_i); while (waitreq_i !== 1'b0);
        q = rdata_i;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/meiu_event_unit_tb.sv
// Self-checking testbench of the event unit
`timescale 1ns/1ps
`default_nettype none
module meiu_event_unit_tb;
    import meiu_pkg::*;
    logic                  clock_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    logic [ADDR_W-1:0]     adr;
    logic                  rd, wr, wreq, irq, rv, tick;
    logic                  sl = 1'b0, cd = 1'b0, cs = 1'b0;
    logic [31:0]           wdat, rdat, raw = '0;
    logic [3:0]            be;
    logic [NPH-1:0]        zx = '0, aov = '0, rs = '0, qs = '0;
    logic [15:0]           ck = '0;
    logic [NPH*OVF_W-1:0]  eo = '0, fo = '0;
    logic [NPH*24-1:0]     ri = '0, vv = {3{24'h100000}};
    int                    n_mismatch = 0, checks_done = 0, cyc = 0;
    meiu_host_model i_host (.clock_i(clock_i), .waitreq_i(wreq), .rdata_i(rdat), .addr_o(adr), .rd_o(rd),
        .wr_o(wr), .wdata_o(wdat), .be_o(be));
    meiu_event_unit i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .supply_low_i(sl), .zero_cross_i(zx), .config_checksum_i(ck),
        .acc_overflow_i(aov), .phase_energy_overflow_i(eo), .phase_fundamental_overflow_i(fo),
        .cycle_done_i(cd), .cycle_start_i(cs), .rms_current_i(ri), .rms_voltage_i(vv), .real_sign_i(rs),
        .react_sign_i(qs), .virt_raw_i(raw), .irq_o(irq), .results_valid_o(rv), .frame_tick_o(tick));
    always #12.5 clock_i = ~clock_i;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input int n); repeat (n) @(posedge clock_i); endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.access(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host.access(1'b0, a, '0, q);
        chk(q, e);
    endtask
    task automatic clr;
        wr_reg(IDX_FLAG, 32'h7FF);
        wr_reg(IDX_PH_FLAGS, 32'hFFFFFFFF);
        wr_reg(IDX_PH_OVF, 32'hFFFFFFFF);
    endtask
    task automatic done_pulse;
        @(posedge clock_i);
        cd <= 1'b1;
        @(posedge clock_i);
        cd <= 1'b0;
        w(3);
    endtask
    task automatic t_regs;
        logic [31:0] e [6] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h100, 32'h13F};
        for (int i = 0; i < 6; i++) rc(4'(i), e[i]);
        wr_reg(4'hD, 32'hFFFFFFFF);
        rc(4'hD, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_supply;
        wr_reg(IDX_MASK, 32'h7FF);
        sl <= 1'b1;
        w(6);
        rc(IDX_FLAG, 32'h1);
        chk(irq, 1'b1);
        wr_reg(IDX_FLAG, 32'h1);
        rc(IDX_FLAG, 32'h1);
        sl <= 1'b0;
        w(4);
        wr_reg(IDX_MASK, 32'h0);
        w(2);
        chk(irq, 1'b0);
        wr_reg(IDX_MASK, 32'h7FF);
        w(2);
        chk(irq, 1'b1);
        wr_reg(IDX_FLAG, 32'h1);
        w(2);
        chk(irq, 1'b0);
        $display("test supply done");
    endtask
    task automatic t_events;
        @(posedge clock_i);
        ck <= 16'h1234;
        aov <= 3'b010;
        eo <= 15'h0080;
        fo <= 15'h0800;
        @(posedge clock_i);
        aov <= '0;
        eo <= '0;
        fo <= '0;
        w(3);
        rc(IDX_FLAG, 32'h6);
        rc(IDX_PH_OVF, 32'h0800_0080);
        clr();
        $display("test events done");
    endtask
    task automatic t_cycle;
        wr_reg(IDX_THR_I, 32'h1000);
        wr_reg(IDX_THR_V, 32'h0010_2000);
        ri <= {24'h0, 24'h0, 24'h100000};
        vv <= {24'h100000, 24'h001100, 24'h2000FF};
        done_pulse();
        rc(IDX_FLAG, 32'h200);
        clr();
        ri <= {24'h100100, 24'h0, 24'h0};
        vv <= {24'h100000, 24'h001000, 24'h200100};
        rs <= 3'b010;
        done_pulse();
        rc(IDX_FLAG, 32'h2B8);
        rc(IDX_PH_FLAGS, 32'h0001_1402);
        clr();
        ri <= '0;
        vv <= {3{24'h100000}};
        qs <= 3'b100;
        done_pulse();
        rc(IDX_FLAG, 32'h300);
        clr();
        $display("test cycle done");
    endtask
    task automatic t_overrun;
        repeat (2) begin
            @(posedge clock_i);
            cs <= 1'b1;
            @(posedge clock_i);
            cs <= 1'b0;
        end
        w(4);
        chk(rv, 1'b0);
        rc(IDX_FLAG, 32'h400);
        // Results of this cycle are dropped by the host
        done_pulse();
        clr();
        w(2);
        chk(rv, 1'b1);
        $display("test overrun done");
    endtask
    task automatic t_virt;
        logic [63:0] p;
        raw <= 32'h07654AF0;
        for (int i = 0; i < 4; i++) begin
            wr_reg(IDX_COEFF_SEL, 32'(i));
            wr_reg(IDX_COEFF, 32'h190 + 32'(i));
            wr_reg(IDX_VIRT_SEL, 32'(i));
            p = 64'(raw) * (64'h190 + 64'(i));
            rc(IDX_VIRT, p[47:16]);
        end
        $display("test virt done");
    endtask
    task automatic t_missing_crossing_flag;
        int n = 0;
        wr_reg(IDX_RATE, 32'h1);
        w(2);
        while (tick !== 1'b1) @(posedge clock_i);
        do begin
            @(posedge clock_i);
            n++;
        end while (tick !== 1'b1);
        chk(32'(n), 32'd16);
        clr();
        wr_reg(IDX_TIMEOUT, 32'h2);
        w(80);
        rc(IDX_FLAG, 32'h40);
        rc(IDX_STATUS, 32'hE);
        zx <= '1;
        w(4);
        clr();
        rc(IDX_FLAG, 32'h0);
        wr_reg(IDX_TIMEOUT, 32'h0);
        clr();
        rc(IDX_FLAG, 32'h0);
        $display("test missing_crossing_flag done");
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_supply();
        t_events();
        t_cycle();
        t_overrun();
        t_virt();
        t_missing_crossing_flag();
        wrap_up();
    end
endmodule
`default_nettype wire
